// ### core/deac_ctrl.sv
`timescale 1ns/1ps
module deac_ctrl #(
    parameter logic [6:0] SWITCH_CMD = deac_pkg::DEFAULT_SWITCH_CMD,
    parameter int CUR_W = deac_pkg::CURSOR_ADDR_W
) (
    // clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // direct register port
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [15:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    output logic [7:0] reg_rdata,
    // indirect command port
    input wire logic cmd_valid,
    input wire logic [7:0] cmd_code,
    input wire logic param_valid,
    input wire logic [7:0] param_data,
    // display memory access and cursor
    input wire logic mem_wr,
    input wire logic mem_rd,
    input wire logic cursor_load,
    input wire logic [CUR_W-1:0] cursor_load_addr,
    output logic [CUR_W-1:0] cursor_addr,
    // system status and timing
    input wire logic power_save,
    input wire logic dual_panel,
    input wire logic frame_start,
    // visibility to the display pipeline
    output logic panel_on,
    output logic first_screen_block_on,
    output logic second_screen_block_on,
    output logic third_screen_block_on,
    output logic fourth_screen_block_on,
    output logic cursor_on
);

    // ----------------------------------------
    // functions
    // ----------------------------------------

    // block visibility for one attribute field
    function automatic logic block_vis(
        input logic [1:0] attr,
        input logic [deac_pkg::FRAME_CNT_W-1:0] cnt
    );
        logic [deac_pkg::FRAME_CNT_W-1:0] slow_mod;
        logic [deac_pkg::FRAME_CNT_W-1:0] fast_mod;
        slow_mod = cnt % deac_pkg::FRAME_CNT_W'(deac_pkg::BLOCK_SLOW_FRAMES);
        fast_mod = cnt % deac_pkg::FRAME_CNT_W'(deac_pkg::BLOCK_FAST_FRAMES);
        case (attr)
            deac_pkg::ATTR_BLANK: block_vis = 1'b0;
            deac_pkg::ATTR_STEADY: block_vis = 1'b1;
            // half on, half off
            deac_pkg::ATTR_FLASH_SLOW: block_vis =
                slow_mod < deac_pkg::FRAME_CNT_W'(deac_pkg::BLOCK_SLOW_FRAMES / 2);
            deac_pkg::ATTR_FLASH_FAST: block_vis =
                fast_mod < deac_pkg::FRAME_CNT_W'(deac_pkg::BLOCK_FAST_FRAMES / 2);
            default: block_vis = 1'b0;
        endcase
    endfunction : block_vis

    // cursor visibility, long on-phase while flashing
    function automatic logic cursor_vis(
        input logic [1:0] attr,
        input logic [deac_pkg::FRAME_CNT_W-1:0] cnt
    );
        logic [deac_pkg::FRAME_CNT_W-1:0] slow_mod;
        slow_mod = cnt % deac_pkg::FRAME_CNT_W'(deac_pkg::CURSOR_SLOW_FRAMES);
        case (attr)
            deac_pkg::ATTR_BLANK: cursor_vis = 1'b0;
            deac_pkg::ATTR_STEADY: cursor_vis = 1'b1;
            deac_pkg::ATTR_FLASH_SLOW: cursor_vis =
                slow_mod < deac_pkg::FRAME_CNT_W'(deac_pkg::CURSOR_SLOW_ON);
            // full counter span is the slowest period
            deac_pkg::ATTR_FLASH_FAST: cursor_vis =
                cnt < deac_pkg::FRAME_CNT_W'(deac_pkg::CURSOR_VSLOW_ON);
            default: cursor_vis = 1'b0;
        endcase
    endfunction : cursor_vis

    // ----------------------------------------
    // host-visible registers and internal flags
    // ----------------------------------------
    logic master_enable;
    logic [7:0] attributes;
    logic ps_prev;
    logic param_pending;

    // ----------------------------------------
    // decode
    // ----------------------------------------
    wire logic sel_enable = reg_addr == deac_pkg::ADDR_MASTER_ENABLE;
    wire logic sel_attr = reg_addr == deac_pkg::ADDR_ATTRIBUTES;
    wire logic wr_enable = reg_wr && sel_enable;
    wire logic wr_attr = reg_wr && sel_attr;
    wire logic switch_cmd = cmd_valid && (cmd_code[7:1] == SWITCH_CMD);
    wire logic param_load = param_valid && param_pending;
    wire logic ps_enter = power_save && !ps_prev;
    wire logic cursor_disabled =
        attributes[deac_pkg::CURSOR_LSB +: 2] == deac_pkg::ATTR_BLANK;
    wire logic mem_access = mem_wr || mem_rd;

    // next master enable: power save clears, else host writes, else the switch command
    logic next_master_enable;
    assign next_master_enable =
        ps_enter ? 1'b0 :
        wr_enable ? reg_wdata[deac_pkg::ENABLE_BIT] :
        switch_cmd ? cmd_code[deac_pkg::ENABLE_BIT] :
        master_enable;

    // next attribute value from direct write, parameter, or memory write
    logic [7:0] attr_loaded;
    logic [7:0] next_attributes;
    assign attr_loaded =
        wr_attr ? reg_wdata :
        param_load ? param_data :
        attributes;
    assign next_attributes =
        (mem_wr && cursor_disabled && !wr_attr && !param_load) ?
        {attributes[7:2], deac_pkg::ATTR_STEADY} :
        attr_loaded;

    // read mux, reserved bits read zero
    logic [7:0] next_rdata;
    assign next_rdata =
        sel_enable ? {7'h00, master_enable} :
        sel_attr ? attributes :
        deac_pkg::RDATA_UNMAPPED;

    // control registers
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            master_enable <= deac_pkg::RESET_MASTER_ENABLE[0];
            attributes <= deac_pkg::RESET_ATTRIBUTES;
            ps_prev <= 1'b0;
        end
        else
        begin
            master_enable <= next_master_enable;
            attributes <= next_attributes;
            ps_prev <= power_save;
        end
    end

    // one parameter byte expected after the switch command
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
            param_pending <= 1'b0;
        else if (switch_cmd)
            param_pending <= 1'b1;
        else if (param_valid || cmd_valid)
            param_pending <= 1'b0;
    end

    // registered read data
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
            reg_rdata <= deac_pkg::RDATA_UNMAPPED;
        else if (reg_rd)
            reg_rdata <= next_rdata;
    end

    // ----------------------------------------
    // cursor position
    // ----------------------------------------
    logic [CUR_W-1:0] next_cursor_addr;
    assign next_cursor_addr =
        cursor_load ? cursor_load_addr :
        mem_access ? cursor_addr + CUR_W'(1) :
        cursor_addr;

    // cursor address register
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
            cursor_addr <= '0;
        else
            cursor_addr <= next_cursor_addr;
    end

    // ----------------------------------------
    // frame counter and frame-aligned copies
    // ----------------------------------------
    logic [deac_pkg::FRAME_CNT_W-1:0] frame_cnt;
    logic act_enable;
    logic [7:0] act_attr;
    logic act_dual;

    // free-running frame counter
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
            frame_cnt <= '0;
        else if (frame_start)
            frame_cnt <= frame_cnt + deac_pkg::FRAME_CNT_W'(1);
    end

    // settings copied at frame boundary; power save blanks at once
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            act_enable <= 1'b0;
            act_attr <= deac_pkg::RESET_ATTRIBUTES;
            act_dual <= 1'b0;
        end
        else if (ps_enter)
            act_enable <= 1'b0;
        else if (frame_start)
        begin
            act_enable <= master_enable;
            act_attr <= attributes;
            act_dual <= dual_panel;
        end
    end

    // ----------------------------------------
    // visibility outputs
    // ----------------------------------------
    logic [deac_pkg::FRAME_CNT_W-1:0] phase_cnt;
    logic vis_first;
    logic vis_second;
    logic vis_third;
    logic vis_cursor;
    assign phase_cnt = frame_start ? frame_cnt + deac_pkg::FRAME_CNT_W'(1) : frame_cnt;
    assign vis_first = block_vis(act_attr[deac_pkg::FIRST_LSB +: 2], phase_cnt);
    assign vis_second = block_vis(act_attr[deac_pkg::SECOND_LSB +: 2], phase_cnt);
    assign vis_third = block_vis(act_attr[deac_pkg::THIRD_LSB +: 2], phase_cnt);
    assign vis_cursor = cursor_vis(act_attr[deac_pkg::CURSOR_LSB +: 2], phase_cnt);

    // enable gates everything
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            panel_on <= 1'b0;
            first_screen_block_on <= 1'b0;
            second_screen_block_on <= 1'b0;
            third_screen_block_on <= 1'b0;
            fourth_screen_block_on <= 1'b0;
            cursor_on <= 1'b0;
        end
        else
        begin
            panel_on <= act_enable;
            first_screen_block_on <= act_enable && vis_first;
            second_screen_block_on <= act_enable && vis_second;
            third_screen_block_on <= act_enable && vis_third;
            fourth_screen_block_on <= act_enable && act_dual && vis_second;
            cursor_on <= act_enable && vis_cursor;
        end
    end

endmodule : deac_ctrl

// ### core/deac_pkg.sv
package deac_pkg;
    // ----------------------------------------
    // register map
    // ----------------------------------------
    localparam logic [15:0] ADDR_MASTER_ENABLE = 16'h8009;
    localparam logic [15:0] ADDR_ATTRIBUTES = 16'h800A;
    localparam logic [7:0] RESET_MASTER_ENABLE = 8'h00;
    localparam logic [7:0] RESET_ATTRIBUTES = 8'h00;
    // ----------------------------------------
    // field positions
    // ----------------------------------------
    localparam int ENABLE_BIT = 0;
    localparam int THIRD_LSB = 6;
    localparam int SECOND_LSB = 4;
    localparam int FIRST_LSB = 2;
    localparam int CURSOR_LSB = 0;
    // ----------------------------------------
    // attribute encodings
    // ----------------------------------------
    localparam logic [1:0] ATTR_BLANK = 2'h0;
    localparam logic [1:0] ATTR_STEADY = 2'h1;
    localparam logic [1:0] ATTR_FLASH_SLOW = 2'h2;
    localparam logic [1:0] ATTR_FLASH_FAST = 2'h3;
    // ----------------------------------------
    // flash timing in frames
    // ----------------------------------------
    localparam int FRAME_CNT_W = 6;
    localparam int BLOCK_SLOW_FRAMES = 32;
    localparam int BLOCK_FAST_FRAMES = 4;
    localparam int CURSOR_SLOW_FRAMES = 32;
    localparam int CURSOR_VSLOW_FRAMES = 64;
    localparam int CURSOR_DUTY_PCT = 70;
    // on-time in frames, rounded to nearest
    localparam int CURSOR_SLOW_ON = (CURSOR_SLOW_FRAMES * CURSOR_DUTY_PCT + 50) / 100;
    localparam int CURSOR_VSLOW_ON = (CURSOR_VSLOW_FRAMES * CURSOR_DUTY_PCT + 50) / 100;
    // ----------------------------------------
    // indirect command, unmapped read value and cursor address width
    // ----------------------------------------
    localparam logic [6:0] DEFAULT_SWITCH_CMD = 7'h01; // arbitrary value
    localparam logic [7:0] RDATA_UNMAPPED = 8'h00;
    localparam int CURSOR_ADDR_W = 15;
endpackage : deac_pkg

// ### testbench/deac_props.sv
`timescale 1ns/1ps
module deac_props #(
    parameter int CUR_W = deac_pkg::CURSOR_ADDR_W
) (
    // clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // host side
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [15:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic [7:0] reg_rdata,
    input wire logic mem_wr,
    input wire logic mem_rd,
    input wire logic cursor_load,
    input wire logic [CUR_W-1:0] cursor_addr,
    input wire logic power_save,
    input wire logic frame_start,
    // panel side
    input wire logic panel_on,
    input wire logic first_screen_block_on,
    input wire logic third_screen_block_on,
    input wire logic cursor_on
);
    default clocking @(posedge clk);
    endclocking
    default disable iff (!rst_n);
    // enable write, one cycle without power save, enable read
    sequence en_wr_rd;
        reg_wr && reg_addr == 16'h8009 && !power_save ##1 !power_save
            ##1 reg_rd && reg_addr == 16'h8009 && !power_save;
    endsequence
    en_readback_a: assert property (
        en_wr_rd |=> reg_rdata == {7'h00, $past(reg_wdata[0], 3)}) else $error("enable readback");
    en_bits_a: assert property (
        reg_rd && reg_addr == 16'h8009 |=> reg_rdata[7:1] == 7'h00) else $error("enable bits");
    cursor_gate_a: assert property (
        !panel_on |-> !cursor_on) else $error("cursor shown while off");
    blocks_gate_a: assert property (
        !panel_on |-> !first_screen_block_on && !third_screen_block_on) else $error("block on");
    ps_clear_a: assert property (
        $rose(power_save) |-> ##[1:2] !panel_on) else $error("power save kept display");
    wr_advance_a: assert property (
        mem_wr && !cursor_load |=> cursor_addr == CUR_W'($past(cursor_addr) + 1'b1))
        else $error("write did not advance");
    rd_advance_a: assert property (
        mem_rd && !cursor_load |=> cursor_addr == CUR_W'($past(cursor_addr) + 1'b1))
        else $error("read did not advance");
    frame_hold_a: assert property (
        !frame_start && !$past(frame_start) && !power_save && !$past(power_save)
        |=> $stable(panel_on)) else $error("panel changed mid frame");
endmodule : deac_props

// ### testbench/deac_host.sv
`timescale 1ns/1ps
module deac_host (
    // clock
    input wire logic clk,
    // register, command and memory strobes
    output logic reg_wr,
    output logic reg_rd,
    output logic [15:0] reg_addr,
    output logic [7:0] reg_wdata,
    input wire logic [7:0] reg_rdata,
    output logic cmd_valid,
    output logic [7:0] cmd_code,
    output logic param_valid,
    output logic [7:0] param_data,
    output logic mem_wr,
    output logic mem_rd
);
    // idle at time zero
    initial
    begin
        {mem_rd, mem_wr, param_valid, cmd_valid, reg_rd, reg_wr} = 6'h00;
        {reg_addr, reg_wdata, cmd_code, param_data} = 40'h0;
    end
    // one transfer: 0 wr, 1 rd, 2 command, 3 parameter, 4 mem wr, 5 mem rd
    task xfer(input int k, input logic [15:0] a, input logic [7:0] d, output logic [7:0] q);
        @(posedge clk);
        reg_addr <= a;
        reg_wdata <= d;
        cmd_code <= d;
        param_data <= d;
        {mem_rd, mem_wr, param_valid, cmd_valid, reg_rd, reg_wr} <= 6'(1 << k);
        @(posedge clk);
        {mem_rd, mem_wr, param_valid, cmd_valid, reg_rd, reg_wr} <= 6'h00;
        reg_addr <= ~a;
        reg_wdata <= ~d;
        #1 q = reg_rdata;
    endtask : xfer
endmodule : deac_host

// ### testbench/tb_top.sv
`timescale 1ns/1ps
module tb_top;
    logic clk, rst_n, cursor_load, power_save, dual_panel, frame_start;
    logic reg_wr, reg_rd, cmd_valid, param_valid, mem_wr, mem_rd, panel_on, cursor_on;
    logic first_screen_block_on, second_screen_block_on;
    logic third_screen_block_on, fourth_screen_block_on;
    logic [15:0] reg_addr;
    logic [7:0] reg_wdata, reg_rdata, cmd_code, param_data, q;
    logic [14:0] cursor_load_addr, cursor_addr, ca;
    int failures, checks, ph;
    deac_host host_u (.clk, .reg_wr, .reg_rd, .reg_addr, .reg_wdata, .reg_rdata,
        .cmd_valid, .cmd_code, .param_valid, .param_data, .mem_wr, .mem_rd);
    deac_ctrl dut_u (.clk, .rst_n, .reg_wr, .reg_rd, .reg_addr, .reg_wdata, .reg_rdata,
        .cmd_valid, .cmd_code, .param_valid, .param_data, .mem_wr, .mem_rd, .cursor_load,
        .cursor_load_addr, .cursor_addr, .power_save, .dual_panel, .frame_start, .panel_on,
        .first_screen_block_on, .second_screen_block_on, .third_screen_block_on,
        .fourth_screen_block_on, .cursor_on);
    // compare and count
    task chk(input logic [15:0] got, input logic [15:0] exp);
        checks++;
        if (got !== exp)
        begin
            failures++;
            $display("[ERR] %0t got %0h exp %0h", $time, got, exp);
        end
    endtask : chk
    task rc(input logic [15:0] a, input logic [7:0] e);
        host_u.xfer(1, a, 8'h00, q);
        chk(q, e);
    endtask : rc
    // one frame boundary pulse, then settle
    task frame;
        @(posedge clk);
        frame_start <= 1'h1;
        @(posedge clk);
        frame_start <= 1'h0;
        ph = (ph + 1) % 64;
        @(posedge clk);
        #1;
    endtask : frame
    task results;
        $display("checks %0d failures %0d", checks, failures);
        if (failures == 0 && checks > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask : results
    initial
    begin
        clk = 1'h0;
        forever #12.5 clk = ~clk;
    end
    // watchdog
    initial
    begin
        #1000000;
        failures++;
        results();
    end
    // main sequence
    initial
    begin
        {rst_n, cursor_load, power_save, dual_panel, frame_start} = 5'h00;
        {cursor_load_addr, ph, failures, checks} = 0;
        repeat (6) @(posedge clk);
        rst_n <= 1'h1;
        rc(16'h8009, 8'h00);
        rc(16'h800A, 8'h00);
        host_u.xfer(0, 16'h8009, 8'hFF, q);
        rc(16'h8009, 8'h01);
        rc(16'h8008, 8'h00);
        chk(panel_on, 0);
        for (int c = 0; c < 4; c++)
        begin
            host_u.xfer(0, 16'h800A, {6'h39, 2'(c)}, q);
            for (int f = 0; f < 64; f++)
            begin
                frame();
                chk(third_screen_block_on, ph % 4 < 2);
                chk(second_screen_block_on, ph % 32 < 16);
                chk(first_screen_block_on, 1);
                chk(cursor_on, c < 2 ? c : c == 2 ? ph % 32 < 22 : ph < 45);
            end
        end
        chk(fourth_screen_block_on, 0);
        @(posedge clk);
        dual_panel <= 1'h1;
        frame();
        chk(fourth_screen_block_on, ph % 32 < 16);
        host_u.xfer(0, 16'h800A, 8'h00, q);
        ca = cursor_addr;
        host_u.xfer(4, 16'h0, 8'h00, q);
        chk(cursor_addr, 15'(ca + 1));
        rc(16'h800A, 8'h01);
        host_u.xfer(0, 16'h800A, 8'h00, q);
        host_u.xfer(5, 16'h0, 8'h00, q);
        chk(cursor_addr, 15'(ca + 2));
        rc(16'h800A, 8'h00);
        @(posedge clk);
        {cursor_load, cursor_load_addr} <= 16'hFFFF;
        @(posedge clk);
        cursor_load <= 1'h0;
        host_u.xfer(4, 16'h0, 8'h00, q);
        chk(cursor_addr, 0);
        host_u.xfer(2, 16'h0, {deac_pkg::DEFAULT_SWITCH_CMD, 1'h0}, q);
        rc(16'h8009, 8'h00);
        host_u.xfer(3, 16'h0, 8'h5A, q);
        rc(16'h800A, 8'h5A);
        host_u.xfer(3, 16'h0, 8'hA5, q);
        rc(16'h800A, 8'h5A);
        frame();
        chk({panel_on, first_screen_block_on, third_screen_block_on, cursor_on}, 0);
        host_u.xfer(2, 16'h0, {deac_pkg::DEFAULT_SWITCH_CMD, 1'h1}, q);
        frame();
        chk(third_screen_block_on, 1);
        // another command disarms the pending parameter
        host_u.xfer(2, 16'h0, 8'hFE, q);
        host_u.xfer(3, 16'h0, 8'h00, q);
        rc(16'h800A, 8'h5A);
        // unmapped write leaves the enable alone
        host_u.xfer(0, 16'h8008, 8'h00, q);
        rc(16'h8009, 8'h01);
        @(posedge clk);
        power_save <= 1'h1;
        repeat (2) @(posedge clk);
        #1 chk(panel_on, 0);
        @(posedge clk);
        power_save <= 1'h0;
        rc(16'h8009, 8'h00);
        results();
    end
endmodule : tb_top
bind deac_ctrl deac_props #(.CUR_W(CUR_W)) props_u (.clk, .rst_n, .reg_wr, .reg_rd, .reg_addr,
    .reg_wdata,
    .reg_rdata, .mem_wr, .mem_rd, .cursor_load, .cursor_addr, .power_save, .frame_start,
    .panel_on, .first_screen_block_on, .third_screen_block_on, .cursor_on);
